// ===== sfpe_core.sv
// Purpose: Command handling for wrapped quad read, discoverable read,
//          page program, quad page program and block erase
// Assumes: Host drives cs/sck/io; memory array lives outside this block
// Notes:   Array writes leave as one strobe per byte, erase as a range
`timescale 1ns/100ps
`include "sfpe_cfg.svh"
module sfpe_core #(
  parameter int PP_CYC = `SFPE_PP_CYC,
  parameter int BE_CYC = `SFPE_BE_CYC,
  parameter logic [255:0] SFDP_TABLE = `SFPE_SFDP_DEF
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        cs_n_in,
  input  wire logic        sck_in,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe_out,
  input  wire logic        quad_enable_bit_in,
  input  wire logic        wel_set_in,
  input  wire logic [4:0]  block_protect_bits_in,
  input  wire logic [7:0]  mem_rdata_in,
  output logic      [23:0] mem_raddr_out,
  output logic             mem_we_out,
  output logic      [23:0] mem_waddr_out,
  output logic      [7:0]  mem_wdata_out,
  output logic             erase_out,
  output logic      [23:0] erase_lo_out,
  output logic      [23:0] erase_hi_out,
  output logic             write_enable_latch_out,
  output logic             ready_busy_flag_out,
  output logic      [2:0]  wrap_field_out
);
  import sfpe_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [5:0] s1_reg, s2_reg, s3_reg;
  always_ff @(posedge ref_clk_in) begin
    s1_reg <= {cs_n_in, sck_in, io_in};
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end
  wire cs_n   = s2_reg[5];
  wire rise   = s2_reg[4] & ~s3_reg[4] & ~cs_n;
  wire fall   = ~s2_reg[4] & s3_reg[4] & ~cs_n;
  wire cs_up  = s2_reg[5] & ~s3_reg[5];

  // ------------------------------------------------------------
  // Command state
  // ------------------------------------------------------------
  sfpe_state_t st_reg, st_next;
  sfpe_kind_t  kd_reg, kd_next;
  logic [7:0]  sh_reg, sh_next;
  logic [3:0]  bc_reg, bc_next;       // Bits in current byte
  logic [2:0]  nb_reg, nb_next;       // Bytes seen, saturates
  logic [23:0] ad_reg, ad_next;
  logic [7:0]  op_reg, op_next;
  logic [8:0]  cnt_reg, cnt_next;     // Data bytes, saturates at 256
  logic [7:0]  ptr_reg, ptr_next;     // Buffer write pointer
  logic [7:0]  buf_mem [256];
  logic [255:0] vld_reg, vld_next;
  logic [2:0]  wr_reg, wr_next;
  logic        wel_reg, wel_next;
  logic        rb_reg, rb_next;
  logic [31:0] tm_reg, tm_next;
  logic [8:0]  wc_reg, wc_next;       // Write-back index
  logic        we_reg, we_next;
  logic [23:0] wa_reg, wa_next;
  logic [7:0]  wd_reg, wd_next;
  logic        er_reg, er_next;
  logic [23:0] elo_reg, elo_next, ehi_reg, ehi_next;
  logic [3:0]  do_reg, do_next, oe_reg, oe_next;
  logic [23:0] ra_reg, ra_next;
  logic        nib_reg, nib_next;   // Low nibble of read byte next
  logic        bufw;

  wire quad     = (kd_reg == SFPE_K_QPP) ||
                  (kd_reg == SFPE_K_RD && op_reg == `SFPE_OP_QREAD);
  wire [3:0] bw = quad ? 4'h4 : 4'h1;
  // Write-back outlives the timer so every buffered byte lands
  wire wb_run   = !wc_reg[8] && op_reg != `SFPE_OP_BE4 &&
                  op_reg != `SFPE_OP_BE32 && op_reg != `SFPE_OP_BE64;
  wire [7:0] shv = (bw == 4'h4) ? {sh_reg[3:0], s2_reg[3:0]}
                                : {sh_reg[6:0], s2_reg[0]};
  wire [3:0] bcv = bc_reg + bw;
  wire byte_done = rise && (bcv == 4'h8);
  // Protection: nonzero block protect bits guard the top region
  wire [4:0] bp = block_protect_bits_in;
  function automatic logic prot(input logic [23:0] a);
    prot = (bp != 5'h0) && (a[23:19] >= (5'h1f - bp));
  endfunction
  // Wrapped read address step
  function automatic logic [23:0] rstep(input logic [23:0] a);
    logic [5:0] m;
    m = 6'h0;
    case (wr_reg[2:1])
      2'h0: m = 6'h07;
      2'h1: m = 6'h0f;
      2'h2: m = 6'h1f;
      default: m = 6'h3f;
    endcase
    if (wr_reg[0])
      rstep = a + 24'h1;
    else
      rstep = {a[23:6], (a[5:0] & ~m) | ((a[5:0] + 6'h1) & m)};
  endfunction

  always_comb begin
    st_next = st_reg;   kd_next = kd_reg;   sh_next = sh_reg;
    bc_next = bc_reg;   nb_next = nb_reg;   ad_next = ad_reg;
    op_next = op_reg;   cnt_next = cnt_reg; ptr_next = ptr_reg;
    vld_next = vld_reg; wr_next = wr_reg;   wel_next = wel_reg;
    rb_next = rb_reg;   tm_next = tm_reg;   wc_next = wc_reg;
    we_next = 1'b0;     wa_next = wa_reg;   wd_next = wd_reg;
    er_next = 1'b0;     elo_next = elo_reg; ehi_next = ehi_reg;
    do_next = do_reg;   oe_next = oe_reg;   ra_next = ra_reg;
    nib_next = nib_reg;
    bufw = 1'b0;
    if (wel_set_in && !rb_reg)
      wel_next = 1'b1;
    case (st_reg)
      SFPE_IDLE, SFPE_ADDR, SFPE_DATA: begin
        if (cs_up) begin
          oe_next = 4'h0;
          st_next = SFPE_DONE;
        end else if (rise) begin
          sh_next = shv;
          bc_next = byte_done ? 4'h0 : bcv;
          if (byte_done) begin
            if (nb_reg != 3'h7)
              nb_next = nb_reg + 3'h1;
            if (nb_reg == 3'h0) begin
              op_next = shv;
              case (shv)
                `SFPE_OP_PP: kd_next = SFPE_K_PP;
                `SFPE_OP_QPP: kd_next = quad_enable_bit_in ?
                                        SFPE_K_QPP : SFPE_K_NONE;
                `SFPE_OP_BE4, `SFPE_OP_BE32,
                `SFPE_OP_BE64: kd_next = SFPE_K_ERA;
                `SFPE_OP_WRAP: kd_next = SFPE_K_WRAP;
                `SFPE_OP_SFDP: kd_next = SFPE_K_RD;
                `SFPE_OP_QREAD: kd_next = quad_enable_bit_in ?
                                          SFPE_K_RD : SFPE_K_NONE;
                default: kd_next = SFPE_K_NONE;
              endcase
              st_next = SFPE_ADDR;
              nib_next = 1'b0;
              vld_next = '0;
              cnt_next = 9'h0;
            end else if (nb_reg <= 3'h3) begin
              ad_next = {ad_reg[15:0], shv};
              if (nb_reg == 3'h3) begin
                st_next = SFPE_DATA;
                ptr_next = shv;
                ra_next = {ad_reg[15:0], shv};
              end
            end else if (kd_reg == SFPE_K_PP || kd_reg == SFPE_K_QPP) begin
              bufw = 1'b1;
              vld_next[ptr_reg] = 1'b1;
              ptr_next = ptr_reg + 8'h1;
              if (cnt_reg != 9'h100)
                cnt_next = cnt_reg + 9'h1;
            end else if (kd_reg == SFPE_K_WRAP && nb_reg == 3'h4) begin
              wr_next = shv[6:4];
            end
          end
        end else if (fall && kd_reg == SFPE_K_RD && st_reg == SFPE_DATA &&
                     nb_reg >= 3'h5) begin
          // One dummy byte then data, msb first
          if (op_reg == `SFPE_OP_SFDP) begin
            oe_next = 4'h2;
            do_next = {2'h0, SFDP_TABLE[255 - ra_reg[7:0]], 1'b0};
            ra_next = ra_reg + 24'h1;
          end else begin
            oe_next = 4'hf;
            do_next = nib_reg ? mem_rdata_in[3:0] : mem_rdata_in[7:4];
            nib_next = ~nib_reg;
            if (nib_reg) begin
              ra_next = rstep(ra_reg);
            end
          end
        end
      end
      SFPE_DONE: begin
        st_next = SFPE_IDLE;
        kd_next = SFPE_K_NONE;
        nb_next = 3'h0;
        bc_next = 4'h0;
        if (kd_reg == SFPE_K_PP || kd_reg == SFPE_K_QPP) begin
          if (bc_reg != 4'h0 || cnt_reg == 9'h0 || !wel_reg ||
              prot(ad_reg)) begin
            wel_next = 1'b0;
          end else begin
            st_next = SFPE_BUSY;
            rb_next = 1'b1;
            tm_next = PP_CYC;
            wc_next = 9'h0;
          end
        end else if (kd_reg == SFPE_K_ERA) begin
          if (bc_reg != 4'h0 || nb_reg < 3'h4 || !wel_reg ||
              prot(ad_reg)) begin
            wel_next = 1'b0;
          end else begin
            st_next = SFPE_BUSY;
            rb_next = 1'b1;
            tm_next = BE_CYC;
            er_next = 1'b1;
            case (op_reg)
              `SFPE_OP_BE4: elo_next = {ad_reg[23:12], 12'h0};
              `SFPE_OP_BE32: elo_next = {ad_reg[23:15], 15'h0};
              default: elo_next = {ad_reg[23:16], 16'h0};
            endcase
            case (op_reg)
              `SFPE_OP_BE4: ehi_next = {ad_reg[23:12], 12'hfff};
              `SFPE_OP_BE32: ehi_next = {ad_reg[23:15], 15'h7fff};
              default: ehi_next = {ad_reg[23:16], 16'hffff};
            endcase
          end
        end
      end
      SFPE_BUSY: begin
        if (wb_run) begin
          wc_next = wc_reg + 9'h1;
          if (vld_reg[wc_reg[7:0]]) begin
            we_next = 1'b1;
            wa_next = {ad_reg[23:8], wc_reg[7:0]};
            wd_next = buf_mem[wc_reg[7:0]];
          end
        end
        if (tm_reg == 32'h1)
          wel_next = 1'b0;
        if (tm_reg == 32'h0) begin
          if (!wb_run) begin
            rb_next = 1'b0;
            st_next = SFPE_IDLE;
          end
        end else begin
          tm_next = tm_reg - 32'h1;
        end
      end
      default: st_next = SFPE_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (bufw)
      buf_mem[ptr_reg] <= shv;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      st_reg <= SFPE_IDLE;  kd_reg <= SFPE_K_NONE; sh_reg <= 8'h0;
      bc_reg <= 4'h0;       nb_reg <= 3'h0;        ad_reg <= 24'h0;
      op_reg <= 8'h0;       cnt_reg <= 9'h0;       ptr_reg <= 8'h0;
      vld_reg <= '0;        wr_reg <= `SFPE_WRAP_RST;
      wel_reg <= 1'b0;      rb_reg <= 1'b0;        tm_reg <= 32'h0;
      wc_reg <= 9'h0;       we_reg <= 1'b0;        wa_reg <= 24'h0;
      wd_reg <= 8'h0;       er_reg <= 1'b0;        elo_reg <= 24'h0;
      ehi_reg <= 24'h0;     do_reg <= 4'h0;        oe_reg <= 4'h0;
      ra_reg <= 24'h0;      nib_reg <= 1'b0;
    end else begin
      st_reg <= st_next;    kd_reg <= kd_next;     sh_reg <= sh_next;
      bc_reg <= bc_next;    nb_reg <= nb_next;     ad_reg <= ad_next;
      op_reg <= op_next;    cnt_reg <= cnt_next;   ptr_reg <= ptr_next;
      vld_reg <= vld_next;  wr_reg <= wr_next;
      wel_reg <= wel_next;  rb_reg <= rb_next;     tm_reg <= tm_next;
      wc_reg <= wc_next;    we_reg <= we_next;     wa_reg <= wa_next;
      wd_reg <= wd_next;    er_reg <= er_next;     elo_reg <= elo_next;
      ehi_reg <= ehi_next;  do_reg <= do_next;     oe_reg <= oe_next;
      ra_reg <= ra_next;    nib_reg <= nib_next;
    end
  end

  assign io_out                 = do_reg;
  assign io_oe_out              = oe_reg;
  assign mem_raddr_out          = ra_reg;
  assign mem_we_out             = we_reg;
  assign mem_waddr_out          = wa_reg;
  assign mem_wdata_out          = wd_reg;
  assign erase_out              = er_reg;
  assign erase_lo_out           = elo_reg;
  assign erase_hi_out           = ehi_reg;
  assign write_enable_latch_out = wel_reg;
  assign ready_busy_flag_out    = rb_reg;
  assign wrap_field_out         = wr_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_wrap_reset: assert property (@(posedge ref_clk_in)
    $rose(rst_n_in) |-> wr_reg == 3'h1) else $error("wrap reset");
  a_busy_on_prog: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    st_reg == SFPE_BUSY |-> rb_reg) else $error("busy flag low");
  a_wel_abort: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (st_reg == SFPE_DONE && kd_reg == SFPE_K_PP && bc_reg != 4'h0)
    |=> !wel_reg && st_reg == SFPE_IDLE) else $error("abort kept wel");
  a_erase_abort: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (st_reg == SFPE_DONE && kd_reg == SFPE_K_ERA && nb_reg < 3'h4)
    |=> !er_reg && !wel_reg) else $error("erase not aborted");
  a_erase_align: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    er_reg |-> erase_lo_out[11:0] == 12'h0 &&
    erase_hi_out[11:0] == 12'hfff) else $error("erase misaligned");
  a_page_stay: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    we_reg |-> wa_reg[23:8] == ad_reg[23:8]) else $error("left page");
  a_qpp_gate: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (rise && byte_done && nb_reg == 3'h0 && shv == `SFPE_OP_QPP &&
     !quad_enable_bit_in) |=> kd_reg != SFPE_K_QPP) else $error("qe");
  a_busy_end: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    $fell(rb_reg) |-> !wel_reg) else $error("wel at end");
  c_prog: cover property (@(posedge ref_clk_in) $rose(we_reg));
  c_erase: cover property (@(posedge ref_clk_in) $rose(er_reg));
  c_wrap: cover property (@(posedge ref_clk_in) $changed(wr_reg));
endmodule : sfpe_core

// ===== sfpe_cfg.svh
// Purpose: Constants for the serial flash program/erase command block
// Assumes: 250 MHz core clock, SPI mode 0/3 sampled by that clock
// Notes:   Times are in ns; cycle counts derive from them
`ifndef SFPE_CFG_SVH
`define SFPE_CFG_SVH
`define SFPE_OP_WRAP     8'h77
`define SFPE_OP_SFDP     8'h5a
`define SFPE_OP_QREAD    8'he7
`define SFPE_OP_PP       8'h02
`define SFPE_OP_QPP      8'h32
`define SFPE_OP_BE4      8'h20
`define SFPE_OP_BE32     8'h52
`define SFPE_OP_BE64     8'hd8
`define SFPE_WRAP_RST    3'h1
`define SFPE_CLK_NS      4
`define SFPE_PP_NS       400000
`define SFPE_BE_NS       50000000
`define SFPE_PP_CYC      (`SFPE_PP_NS / `SFPE_CLK_NS)
`define SFPE_BE_CYC      (`SFPE_BE_NS / `SFPE_CLK_NS)
`define SFPE_SFDP_DEF    256'h0
`endif

// ===== sfpe_pkg.sv
// Purpose: Types for the serial flash program/erase command block
// Assumes: Nothing beyond the cfg header
// Notes:   States Gray coded along the usual path from IDLE to BUSY; BUSY back to IDLE flips two bits
package sfpe_pkg;
  typedef enum logic [2:0] {
    SFPE_IDLE = 3'h0,
    SFPE_ADDR = 3'h1,
    SFPE_DATA = 3'h3,
    SFPE_DONE = 3'h2,
    SFPE_BUSY = 3'h6
  } sfpe_state_t;
  typedef enum logic [2:0] {
    SFPE_K_NONE = 3'h0,
    SFPE_K_PP   = 3'h1,
    SFPE_K_QPP  = 3'h2,
    SFPE_K_ERA  = 3'h3,
    SFPE_K_WRAP = 3'h4,
    SFPE_K_RD   = 3'h5
  } sfpe_kind_t;
endpackage : sfpe_pkg

// ===== sfpe_host.sv
// Purpose: Host controller model that drives the flash command pins
// Assumes: Core clock paces the serial clock, 20 core cycles a period
// Notes:   Serial clock rests low between frames; io lines inverted after
`timescale 1ns/100ps
module sfpe_host (
  input  wire logic       ref_clk_in,
  output logic            cs_n_out,
  output logic            sck_out,
  output logic      [3:0] io_out
);
  initial begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    io_out   = 4'h0;
  end
  task automatic half();
    repeat (10) @(posedge ref_clk_in);
    #1;
  endtask : half
  // One clock per bit, or per nibble in quad mode
  task automatic shift(input logic [7:0] b, input int n, input bit quad);
    for (int i = 0; i < n; i++) begin
      if (quad) begin
        io_out = (i % 2 == 0) ? b[7:4] : b[3:0];
      end else begin
        // Unused lines toggle so a stale level is never read as data
        io_out = {~io_out[3:1], b[7 - i]};
      end
      half();
      sck_out = 1'b1;
      half();
      sck_out = 1'b0;
    end
  endtask : shift
  task automatic frame(input logic [7:0] op, input logic [23:0] addr,
                       input int nadr, input int ndat,
                       input logic [7:0] seed, input int extra,
                       input bit quad);
    int w;
    w = quad ? 2 : 8;
    cs_n_out = 1'b0;
    half();
    shift(op, 8, 1'b0);
    for (int a = 0; a < nadr; a++) shift(addr[23 - 8 * a -: 8], w, quad);
    for (int d = 0; d < ndat; d++) shift(8'(seed + d * 7), w, quad);
    if (extra > 0) shift(8'ha5, extra, quad);
    half();
    cs_n_out = 1'b1;
    io_out   = ~io_out;
    half();
  endtask : frame
endmodule : sfpe_host

// ===== testbench.sv
// Purpose: Self-checking bench for the program/erase command block
// Assumes: Short busy counts of 50 cycles
// Notes:   Array writes land in a one-page shadow
`timescale 1ns/100ps
`include "sfpe_cfg.svh"
module testbench;
  typedef struct {
    logic [7:0]  op;
    logic [23:0] addr;
    int          nadr;
    int          ndat;
    logic [7:0]  seed;
    int          extra;
    bit          quad;
    bit          write_enable_latch;
    bit          qe;
    logic [4:0]  bp;
    bit          ex;
  } sfpe_row_t;
  logic        clk, rst_n, cs_n, sck, qe, wel_set, we, erase, write_enable_latch, busy;
  logic [3:0]  h_io, io_o, io_oe, io_in;
  logic [4:0]  bp;
  logic [7:0]  wdata;
  logic [23:0] raddr, waddr, elo, ehi, lo_seen, hi_seen;
  logic [2:0]  wrap;
  logic [7:0]  shadow [256];
  logic [15:0] page;
  logic        busy_seen, wel_last;
  int          wr_cnt, er_cnt, off_page, failures, check_count;
  sfpe_row_t rows [24] = '{
    '{8'h02, 24'h0000fe, 3, 3, 8'h01, 0, 0, 1, 0, 5'h00, 1},
    '{8'h02, 24'h001200, 3, 1, 8'h3c, 0, 0, 1, 0, 5'h00, 1},
    '{8'h02, 24'h000010, 3, 258, 8'h05, 0, 0, 1, 0, 5'h00, 1},
    '{8'h02, 24'h000300, 3, 0, 8'h00, 0, 0, 1, 0, 5'h00, 0},
    '{8'h02, 24'h000300, 3, 2, 8'h11, 3, 0, 1, 0, 5'h00, 0},
    '{8'h02, 24'h000300, 2, 0, 8'h11, 4, 0, 1, 0, 5'h00, 0},
    '{8'h02, 24'h000300, 3, 2, 8'h11, 0, 0, 0, 0, 5'h00, 0},
    '{8'h02, 24'hf80004, 3, 2, 8'h11, 0, 0, 1, 0, 5'h01, 0},
    '{8'h32, 24'h0040fe, 3, 4, 8'h21, 0, 1, 1, 1, 5'h00, 1},
    '{8'h32, 24'h004000, 3, 2, 8'h21, 0, 1, 1, 0, 5'h00, 0},
    '{8'h32, 24'hf80000, 3, 2, 8'h21, 0, 1, 1, 1, 5'h01, 0},
    '{8'h32, 24'h004000, 3, 1, 8'h21, 1, 1, 1, 1, 5'h00, 0},
    '{8'h20, 24'h123abc, 3, 0, 8'h00, 0, 0, 1, 0, 5'h00, 1},
    '{8'h52, 24'h123abc, 3, 0, 8'h00, 0, 0, 1, 0, 5'h00, 1},
    '{8'hd8, 24'h123abc, 3, 0, 8'h00, 0, 0, 1, 0, 5'h00, 1},
    '{8'h20, 24'h0ff123, 3, 2, 8'h77, 0, 0, 1, 0, 5'h00, 1},
    '{8'hd8, 24'h123abc, 2, 0, 8'h00, 0, 0, 1, 0, 5'h00, 0},
    '{8'h52, 24'h010000, 3, 0, 8'h00, 4, 0, 1, 0, 5'h00, 0},
    '{8'h20, 24'hf81000, 3, 0, 8'h00, 0, 0, 1, 0, 5'h01, 0},
    '{8'h77, 24'h000000, 3, 1, 8'h00, 0, 0, 0, 0, 5'h00, 0},
    '{8'h77, 24'h000000, 3, 1, 8'h20, 0, 0, 0, 0, 5'h00, 0},
    '{8'h77, 24'h000000, 3, 1, 8'h40, 0, 0, 0, 0, 5'h00, 0},
    '{8'h77, 24'h000000, 3, 1, 8'h60, 0, 0, 0, 0, 5'h00, 0},
    '{8'h77, 24'h000000, 3, 1, 8'h10, 0, 0, 0, 0, 5'h00, 0}
  };
  assign io_in = (io_oe & io_o) | (~io_oe & h_io);
  sfpe_host u_host (
    .ref_clk_in (clk),
    .cs_n_out   (cs_n),
    .sck_out    (sck),
    .io_out     (h_io)
  );
  sfpe_core #(.PP_CYC(50), .BE_CYC(50)) u_dut (
    .ref_clk_in             (clk),
    .rst_n_in               (rst_n),
    .cs_n_in                (cs_n),
    .sck_in                 (sck),
    .io_in                  (io_in),
    .io_out                 (io_o),
    .io_oe_out              (io_oe),
    .quad_enable_bit_in     (qe),
    .wel_set_in             (wel_set),
    .block_protect_bits_in  (bp),
    .mem_rdata_in           (raddr[7:0]),
    .mem_raddr_out          (raddr),
    .mem_we_out             (we),
    .mem_waddr_out          (waddr),
    .mem_wdata_out          (wdata),
    .erase_out              (erase),
    .erase_lo_out           (elo),
    .erase_hi_out           (ehi),
    .write_enable_latch_out (write_enable_latch),
    .ready_busy_flag_out    (busy),
    .wrap_field_out         (wrap)
  );
  always #2 clk = ~clk;
  // -------------------------------------------------------------------
  // Monitor
  // -------------------------------------------------------------------
  always @(posedge clk) begin
    if (we === 1'b1) begin
      wr_cnt++;
      shadow[waddr[7:0]] = wdata;
      if (waddr[23:8] !== page) off_page++;
    end
    if (erase === 1'b1) begin
      er_cnt++;
      lo_seen = elo;
      hi_seen = ehi;
    end
    if (busy === 1'b1) begin
      busy_seen = 1'b1;
      wel_last  = write_enable_latch;
    end
  end
  task automatic chk_val(input string n, input logic [23:0] e,
                         input logic [23:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk_val
  task automatic chk_flag(input string n, input logic e, input logic g);
    chk_val(n, {23'h0, e}, {23'h0, g});
  endtask : chk_flag
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
    #1;
  endtask : wait_busy
  task automatic pulse_wel();
    wel_set = 1'b1;
    @(posedge clk);
    #1;
    wel_set = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : pulse_wel
  task automatic run_row(input sfpe_row_t r);
    logic [7:0]  exp [256];
    logic [23:0] m;
    bit          prog;
    prog = (r.op == 8'h02) || (r.op == 8'h32);
    qe = r.qe;
    bp = r.bp;
    if (r.write_enable_latch) pulse_wel();
    chk_flag("latch before", r.write_enable_latch, write_enable_latch);
    wr_cnt = 0;
    er_cnt = 0;
    off_page = 0;
    busy_seen = 1'b0;
    wel_last = 1'b0;
    page = r.addr[23:8];
    foreach (shadow[i]) shadow[i] = 8'hff;
    u_host.frame(r.op, r.addr, r.nadr, r.ndat, r.seed, r.extra, r.quad);
    wait_busy(1'b1, 40);
    wait_busy(1'b0, 400);
    chk_flag("busy seen", r.ex, busy_seen);
    chk_flag("busy end", 1'b0, busy);
    chk_flag("latch at end", 1'b0, wel_last);
    chk_flag("latch after", (r.op == 8'h32 && !r.qe) ? r.write_enable_latch : 1'b0, write_enable_latch);
    chk_val("off page writes", 24'h0, 24'(off_page));
    if (r.op == `SFPE_OP_WRAP) chk_val("wrap", {21'h0, r.seed[6:4]}, {21'h0, wrap});
    if (prog) begin
      foreach (exp[i]) exp[i] = 8'hff;
      for (int i = 0; r.ex && i < r.ndat; i++) exp[8'(r.addr[7:0] + i)] = 8'(r.seed + i * 7);
      foreach (exp[i]) chk_val("array byte", {16'h0, exp[i]}, {16'h0, shadow[i]});
    end else begin
      chk_val("writes", 24'h0, 24'(wr_cnt));
    end
    chk_val("erases", {23'h0, r.ex && !prog}, 24'(er_cnt));
    m = (r.op == 8'h20) ? 24'h000fff : (r.op == 8'h52) ? 24'h007fff : 24'h00ffff;
    if (r.ex && !prog) begin
      chk_val("erase low", r.addr & ~m, lo_seen);
      chk_val("erase high", r.addr | m, hi_seen);
    end
  endtask : run_row
  task automatic chk_reset();
    chk_val("wrap reset", 24'h1, {21'h0, wrap});
    chk_flag("busy reset", 1'b0, busy);
    chk_flag("latch reset", 1'b0, write_enable_latch);
  endtask : chk_reset
  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    #390000;
    failures++;
    summarize();
  end
  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    qe = 1'b0;
    wel_set = 1'b0;
    bp = 5'h00;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    chk_reset();
    foreach (rows[k]) run_row(rows[k]);
    // Eight-byte wrap, then a quad read of four bytes from offset 6
    qe = 1'b1;
    u_host.frame(8'h77, 24'h000000, 3, 1, 8'h00, 0, 1'b0);
    chk_val("wrap set", 24'h0, {21'h0, wrap});
    u_host.frame(8'he7, 24'h000006, 3, 5, 8'h00, 0, 1'b1);
    chk_val("read address", 24'h000002, raddr);
    chk_val("read enable", 24'h0, {20'h0, io_oe});
    // Reset in mid-erase must abandon the cycle and restore the wrap field
    pulse_wel();
    u_host.frame(8'hd8, 24'h020000, 3, 0, 8'h00, 0, 1'b0);
    wait_busy(1'b1, 40);
    chk_flag("busy before reset", 1'b1, busy);
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    chk_reset();
    summarize();
  end
endmodule : testbench
